/* rtl/cpu_irq_host_ctrl.sv */
// Processor end: Wishbone-driven link master with automatic flag service
//
// The Wishbone interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module cpu_irq_host_ctrl
    import cpu_irq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    output logic irq_o,
    cpu_irq_link_if.host link
);
    typedef enum {S_IDLE, S_MANUAL, S_RD_STAT, S_RD_CTRL, S_RD_HIRQ,
                  S_RD_BUF, S_CLR} state_e;
    state_e state;
    logic req_q;
    logic [7:0] code_q;
    logic [15:0] wdata_q;
    logic [15:0] result;
    logic [15:0] snapshot;
    logic [2:0] irq_status;
    logic [2:0] irq_mask;
    logic auto_en;
    logic pin_q;
    logic acc;
    logic done;
    logic [2:0] set_vec;

    assign acc = ce_i && cyc_i && stb_i && !ack_o;
    assign done = ce_i && req_q && link.ack;

    // Wishbone ack one cycle after the strobe, read data with it
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            ack_o <= acc;
            if (acc && !we_i) begin
                case (adr_i)
                    WB_RESULT: dat_o <= {15'h0000, state != S_IDLE, result};
                    WB_IRQ_STATUS: dat_o <= {29'h0, irq_status};
                    WB_IRQ_MASK: dat_o <= {29'h0, irq_mask};
                    WB_SERVICE: dat_o <= {31'h0, auto_en};
                    WB_SNAPSHOT: dat_o <= {16'h0000, snapshot};
                    default: dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Control registers of the controller
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_mask <= 3'h0;
            auto_en <= 1'b0;
        end else if (acc && we_i && sel_i[0]) begin
            if (adr_i == WB_IRQ_MASK) irq_mask <= dat_i[2:0];
            if (adr_i == WB_SERVICE) auto_en <= dat_i[0];
        end
    end

    // Link master and service sequence
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= S_IDLE;
            req_q <= 1'b0;
            code_q <= 8'h00;
            wdata_q <= 16'h0000;
            result <= 16'h0000;
            snapshot <= 16'h0000;
        end else if (ce_i) begin
            if (done) begin
                req_q <= 1'b0;
                result <= link.rdata;
            end
            case (state)
                S_IDLE: begin
                    if (acc && we_i && adr_i == WB_CMD && &sel_i[2:0]) begin
                        state <= S_MANUAL;
                        req_q <= 1'b1;
                        code_q <= dat_i[23:16];
                        wdata_q <= dat_i[15:0];
                    end else if (auto_en && link.irq_out_pin) begin
                        state <= S_RD_STAT;
                        req_q <= 1'b1;
                        code_q <= CODE_STATUS_RD;
                    end
                end
                S_MANUAL: if (done) state <= S_IDLE;
                S_RD_STAT: begin
                    if (done) begin
                        snapshot <= link.rdata;
                        req_q <= 1'b1;
                        // Cause of an operational event lives elsewhere
                        if (link.rdata[BIT_OPR_EVENT]) begin
                            state <= S_RD_CTRL;
                            code_q <= CODE_HOST_CONTROL_RD;
                        end else if (link.rdata[BIT_ASYNC] ||
                                     link.rdata[BIT_FRAME_ISO]) begin
                            state <= S_RD_BUF;
                            code_q <= CODE_BUF_FILL_RD;
                        end else begin
                            state <= S_CLR;
                            code_q <= CODE_STATUS_WR;
                            wdata_q <= link.rdata;
                        end
                    end
                end
                // read both registers that give the cause
                S_RD_CTRL: begin
                    if (done) begin
                        state <= S_RD_HIRQ;
                        req_q <= 1'b1;
                        code_q <= CODE_HOST_IRQ_RD;
                    end
                end
                S_RD_HIRQ: begin
                    if (done) begin
                        req_q <= 1'b1;
                        if (snapshot[BIT_ASYNC] || snapshot[BIT_FRAME_ISO]) begin
                            state <= S_RD_BUF;
                            code_q <= CODE_BUF_FILL_RD;
                        end else begin
                            state <= S_CLR;
                            code_q <= CODE_STATUS_WR;
                            wdata_q <= snapshot;
                        end
                    end
                end
                // fill status read before the flag clear
                // same order for the iso list
                S_RD_BUF: begin
                    if (done) begin
                        state <= S_CLR;
                        req_q <= 1'b1;
                        code_q <= CODE_STATUS_WR;
                        wdata_q <= snapshot;
                    end
                end
                // Clears only what was seen, so late events survive
                S_CLR: if (done) state <= S_IDLE;
                default: state <= S_IDLE;
            endcase
        end
    end
    assign link.req = req_q;
    assign link.code = code_q;
    assign link.wdata = wdata_q;

    // Controller events
    always_comb begin
        set_vec = 3'h0;
        set_vec[HIRQ_DONE] = done && state == S_MANUAL;
        set_vec[HIRQ_PIN] = link.irq_out_pin && !pin_q;
        set_vec[HIRQ_SERVICED] = done && state == S_CLR;
    end

    // Sticky status, cleared by read; set wins
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status <= 3'h0;
            pin_q <= 1'b0;
        end else if (ce_i) begin
            pin_q <= link.irq_out_pin;
            if (acc && !we_i && adr_i == WB_IRQ_STATUS) begin
                irq_status <= set_vec;
            end else begin
                irq_status <= irq_status | set_vec;
            end
        end
    end
    assign irq_o = |(irq_status & irq_mask);
endmodule // cpu_irq_host_ctrl
`default_nettype wire

/* rtl/cpu_irq_link_if.sv */
// Parallel command link between processor-side controller and device
`timescale 1ns/1ps
`default_nettype none
interface cpu_irq_link_if;
    logic req;
    logic [7:0] code;
    logic [15:0] wdata;
    logic ack;
    logic [15:0] rdata;
    logic irq_out_pin;
    modport dev (input req, input code, input wdata,
                 output ack, output rdata, output irq_out_pin);
    modport host (output req, output code, output wdata,
                  input ack, input rdata, input irq_out_pin);
endinterface // cpu_irq_link_if
`default_nettype wire

/* rtl/cpu_irq_pkg.sv */
// Shared constants for the processor-side interrupt status and mask logic
package cpu_irq_pkg;
    // Link command codes: bit 7 set marks a write
    localparam int unsigned WR_BIT = 7;
    localparam logic [7:0] CODE_HOST_CONTROL_RD = 8'h01;
    localparam logic [7:0] CODE_HOST_CONTROL_WR = 8'h81;
    localparam logic [7:0] CODE_HOST_IRQ_RD = 8'h03;
    localparam logic [7:0] CODE_HW_CONFIG_RD = 8'h20;
    localparam logic [7:0] CODE_HW_CONFIG_WR = 8'hA0;
    localparam logic [7:0] CODE_BYTE_COUNT_RD = 8'h22;
    localparam logic [7:0] CODE_BYTE_COUNT_WR = 8'hA2;
    localparam logic [7:0] CODE_STATUS_RD = 8'h24;
    localparam logic [7:0] CODE_STATUS_WR = 8'hA4;
    localparam logic [7:0] CODE_MASK_RD = 8'h25;
    localparam logic [7:0] CODE_MASK_WR = 8'hA5;
    localparam logic [7:0] CODE_BUF_FILL_RD = 8'h2C;
    // Status, mask, config and host control bit positions
    localparam int unsigned BIT_CLK_READY = 6;
    localparam int unsigned BIT_SUSPENDED = 5;
    localparam int unsigned BIT_OPR_EVENT = 4;
    localparam int unsigned BIT_XFER_END = 2;
    localparam int unsigned BIT_ASYNC = 1;
    localparam int unsigned BIT_FRAME_ISO = 0;
    localparam int unsigned BIT_PIN_GATE = 0;
    localparam int unsigned BIT_SUSPEND_REQ = 0;
    localparam logic [15:0] IMPL_MASK = 16'h0077;
    localparam logic [15:0] REG_RESET = 16'h0000;
    // Timing
    localparam int unsigned CLK_KHZ = 25000;
    localparam int unsigned CLK_READY_MAX_US = 1000;
    localparam int unsigned FRAME_US = 1000;
    localparam int unsigned CLK_READY_MAX_CYC = CLK_READY_MAX_US * CLK_KHZ / 1000;
    localparam int unsigned FRAME_CYC = FRAME_US * CLK_KHZ / 1000;
    // Controller Wishbone map (byte addresses)
    localparam logic [7:0] WB_CMD = 8'h00;
    localparam logic [7:0] WB_RESULT = 8'h04;
    localparam logic [7:0] WB_IRQ_STATUS = 8'h08;
    localparam logic [7:0] WB_IRQ_MASK = 8'h0C;
    localparam logic [7:0] WB_SERVICE = 8'h10;
    localparam logic [7:0] WB_SNAPSHOT = 8'h14;
    localparam int unsigned HIRQ_DONE = 0;
    localparam int unsigned HIRQ_PIN = 1;
    localparam int unsigned HIRQ_SERVICED = 2;
    localparam int unsigned BUSY_BIT = 16;
endpackage

/* rtl/host_cpu_irq_status_mask.sv */
// Device end: interrupt status, mask and pin gate of the host controller
//
// Function
// - Clock ready flag within 1 ms of wake-up
// - Flag bit 5 on entering suspend
// - Suspend via host control; then stop SOF
// - Operational event sets bit 4
// - Internal or external end sets bit 2
// - Async list data sets bit 1
// - Each 1 ms frame mark sets bit 0
// - Mask bits 6..4 and 2..0 enable matching flags
// - Pin needs flag, mask and gate
// - Mask clears to zero at reset
// - Read keeps flags; write one clears
// - Byte count match raises internal end
// - Config bit 0 gates the pin
`timescale 1ns/1ps
`default_nettype none
module host_cpu_irq_status_mask
    import cpu_irq_pkg::*;
#(
    parameter int unsigned CLK_READY_CYCLES = CLK_READY_MAX_CYC,
    parameter int unsigned FRAME_CYCLES = FRAME_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    cpu_irq_link_if.dev link,
    input wire logic wakeup_sent_i,
    input wire logic clk_stable_i,
    input wire logic downstream_suspended_i,
    input wire logic opr_event_i,
    input wire logic ext_eot_i,
    input wire logic byte_strobe_i,
    input wire logic async_ready_i,
    input wire logic [15:0] host_irq_status_i,
    input wire logic [15:0] buffer_fill_status_i,
    output logic sof_mark_o,
    output logic suspended_o,
    output logic [15:0] host_control_o
);
    logic [15:0] cpu_irq_status;
    logic [15:0] cpu_irq_mask;
    logic [15:0] hw_config;
    logic [15:0] byte_count_reg;
    logic [15:0] host_control;
    logic [15:0] byte_cnt;
    logic [15:0] frame_cnt;
    logic [15:0] wake_cnt;
    logic waiting_clk;
    logic ack_q;
    logic [15:0] rdata_q;
    logic take;
    logic wr;
    logic suspended;
    logic clk_ready_evt;
    logic suspend_evt;
    logic internal_eot;
    logic frame_tick;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;

    // A request is taken once; ack stands one cycle
    assign take = ce_i && link.req && !ack_q;
    assign wr = link.code[WR_BIT];

    // Link answer: data registered with the ack
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            rdata_q <= REG_RESET;
        end else if (ce_i) begin
            ack_q <= take;
            if (take && !wr) begin
                case (link.code)
                    CODE_STATUS_RD: rdata_q <= cpu_irq_status & IMPL_MASK;
                    CODE_MASK_RD: rdata_q <= cpu_irq_mask & IMPL_MASK;
                    CODE_HW_CONFIG_RD: rdata_q <= hw_config;
                    CODE_BYTE_COUNT_RD: rdata_q <= byte_count_reg;
                    CODE_HOST_CONTROL_RD: rdata_q <= host_control;
                    CODE_HOST_IRQ_RD: rdata_q <= host_irq_status_i;
                    CODE_BUF_FILL_RD: rdata_q <= buffer_fill_status_i;
                    default: rdata_q <= REG_RESET;
                endcase
            end
        end
    end
    assign link.ack = ack_q;
    assign link.rdata = rdata_q;

    // Writable registers
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_irq_mask <= REG_RESET;
            hw_config <= REG_RESET;
            byte_count_reg <= REG_RESET;
            host_control <= REG_RESET;
        end else if (take && wr) begin
            case (link.code)
                CODE_MASK_WR: cpu_irq_mask <= link.wdata & IMPL_MASK;
                CODE_HW_CONFIG_WR: hw_config <= link.wdata;
                CODE_BYTE_COUNT_WR: byte_count_reg <= link.wdata;
                CODE_HOST_CONTROL_WR: host_control <= link.wdata;
                default: ;
            endcase
        end
    end
    assign host_control_o = host_control;

    // wait for stable clock, capped at 1 ms
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            waiting_clk <= 1'b0;
            wake_cnt <= 16'h0000;
        end else if (ce_i) begin
            if (wakeup_sent_i) begin
                waiting_clk <= 1'b1;
                wake_cnt <= 16'h0000;
            end else if (clk_ready_evt) begin
                waiting_clk <= 1'b0;
            end else if (waiting_clk) begin
                wake_cnt <= wake_cnt + 16'h0001;
            end
        end
    end
    assign clk_ready_evt = waiting_clk && !wakeup_sent_i &&
        (clk_stable_i || wake_cnt == 16'(CLK_READY_CYCLES - 1));

    // SOF stops once downstream is suspended too
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            suspended <= 1'b0;
        end else if (ce_i) begin
            suspended <= host_control[BIT_SUSPEND_REQ] && downstream_suspended_i;
        end
    end
    // one event on the way into suspend
    assign suspend_evt = host_control[BIT_SUSPEND_REQ] &&
        downstream_suspended_i && !suspended;
    assign suspended_o = suspended;

    // 1 ms frame timer, cleared while suspended
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_cnt <= 16'h0000;
            sof_mark_o <= 1'b0;
        end else if (ce_i) begin
            sof_mark_o <= frame_tick;
            if (suspended || frame_tick) begin
                frame_cnt <= 16'h0000;
            end else begin
                frame_cnt <= frame_cnt + 16'h0001;
            end
        end
    end
    assign frame_tick = !suspended && frame_cnt == 16'(FRAME_CYCLES - 1);

    // count bytes to the programmed total
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            byte_cnt <= 16'h0000;
        end else if (ce_i) begin
            if ((take && wr && link.code == CODE_BYTE_COUNT_WR) ||
                internal_eot) begin
                byte_cnt <= 16'h0000;
            end else if (byte_strobe_i) begin
                byte_cnt <= byte_cnt + 16'h0001;
            end
        end
    end
    // Zero count never matches, so an unloaded counter stays quiet
    assign internal_eot = byte_strobe_i && byte_count_reg != 16'h0000 &&
        byte_cnt + 16'h0001 == byte_count_reg;

    // Event vector in status layout
    always_comb begin
        set_vec = 16'h0000;
        set_vec[BIT_CLK_READY] = clk_ready_evt;
        set_vec[BIT_SUSPENDED] = suspend_evt;
        set_vec[BIT_OPR_EVENT] = opr_event_i;
        set_vec[BIT_XFER_END] = ext_eot_i || internal_eot;
        set_vec[BIT_ASYNC] = async_ready_i;
        set_vec[BIT_FRAME_ISO] = frame_tick;
    end
    assign clr_vec = (take && wr && link.code == CODE_STATUS_WR) ?
        link.wdata : 16'h0000;

    // Sticky flags; a new event beats a same-cycle clear
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cpu_irq_status <= REG_RESET;
        end else if (ce_i) begin
            cpu_irq_status <= ((cpu_irq_status & ~clr_vec) | set_vec) &
                IMPL_MASK;
        end
    end

    // flag and mask and gate drive the pin
    assign link.irq_out_pin = hw_config[BIT_PIN_GATE] &&
        |(cpu_irq_status & cpu_irq_mask);
endmodule // host_cpu_irq_status_mask
`default_nettype wire

/* test/cpu_irq_link_monitor.sv */
// Checker of the link between the controller and the device end
`timescale 1ns/1ps
`default_nettype none
module cpu_irq_link_monitor
    import cpu_irq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic req,
    input wire logic [7:0] code,
    input wire logic [15:0] wdata,
    input wire logic ack,
    input wire logic [15:0] rdata,
    input wire logic irq_out_pin
);
    logic [15:0] mask_t;
    logic [15:0] seen_t;
    logic gate_t;
    logic taken;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // Clock enable is assumed held high by the bench
    assign taken = req && !ack;
    // Shadow mask and gate, updated at the edge a write is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mask_t <= 16'h0000;
            gate_t <= 1'b0;
        end else if (taken && code == CODE_MASK_WR) begin
            mask_t <= wdata & IMPL_MASK;
        end else if (taken && code == CODE_HW_CONFIG_WR) begin
            gate_t <= wdata[BIT_PIN_GATE];
        end
    end
    // Flags seen at the last read; only a write-one may drop them
    always_ff @(posedge clk_i) begin
        if (rst_i)
            seen_t <= 16'h0000;
        else if (ack && code == CODE_STATUS_RD)
            seen_t <= rdata;
        else if (taken && code == CODE_STATUS_WR)
            seen_t <= seen_t & ~wdata;
    end
    property p_ack_pulse;
        ack |=> !ack;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) // link answer
        else $error("link ack longer than one cycle");
    property p_ack_answer;
        taken |=> ack && $past(req);
    endproperty
    a_ack_answer: assert property (p_ack_answer) // link answer
        else $error("link request not answered next cycle");
    property p_mask_read;
        ack && code == CODE_MASK_RD |-> rdata == mask_t;
    endproperty
    a_mask_read: assert property (p_mask_read)
        else $error("mask readback differs from writes");
    property p_status_resv;
        ack && code == CODE_STATUS_RD |-> (rdata & ~IMPL_MASK) == 16'h0000;
    endproperty
    a_status_resv: assert property (p_status_resv)
        else $error("reserved status bits not zero");
    property p_sticky;
        ack && code == CODE_STATUS_RD |-> (rdata & seen_t) == seen_t;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("status flag lost without a write");
    property p_pin_needs;
        irq_out_pin |-> gate_t && (mask_t != 16'h0000);
    endproperty
    a_pin_needs: assert property (p_pin_needs)
        else $error("pin high without mask and gate");
    property p_pin_on;
        ack && code == CODE_STATUS_RD && gate_t && (rdata & mask_t) != 0
            |-> irq_out_pin;
    endproperty
    a_pin_on: assert property (p_pin_on)
        else $error("pin low with an enabled flag set");
    property p_gate_off;
        taken && code == CODE_HW_CONFIG_WR && !wdata[BIT_PIN_GATE]
            |=> !irq_out_pin [*2];
    endproperty
    a_gate_off: assert property (p_gate_off)
        else $error("pin high with gate cleared");
    c_pin: cover property ($rose(irq_out_pin));
    c_clear: cover property (taken && code == CODE_STATUS_WR);
    c_gate: cover property (taken && code == CODE_HW_CONFIG_WR);
endmodule // cpu_irq_link_monitor
`default_nettype wire

/* test/host_cpu_irq_status_mask_tb_top.sv */
// Bench: controller and device joined over the link, driven by Wishbone
`timescale 1ns/1ps
`default_nettype none
module host_cpu_irq_status_mask_tb_top;
    import cpu_irq_pkg::*;
    localparam int unsigned READY_CYC = 20;
    localparam int unsigned FRAME_LEN = 50;
    typedef struct packed {
        logic [5:0] ev;
        logic [15:0] exp;
    } row_s;
    // Events: wake, stable, operational, ext end, async, byte
    row_s rows [5] = '{'{6'h08, 16'h0010}, '{6'h04, 16'h0004},
        '{6'h02, 16'h0002}, '{6'h20, 16'h0040}, '{6'h00, 16'h0000}};
    logic clk_i, rst_i, cyc, stb, we, wb_ack, irq, down_susp, sof, susp;
    logic [7:0] adr;
    logic [31:0] dat, wb_q, wq;
    logic [5:0] ev;
    logic [15:0] hirq, bfill, rd, hctl;
    int mismatches, checks_done, n;
    cpu_irq_link_if lk();
    host_cpu_irq_status_mask #(.CLK_READY_CYCLES(READY_CYC),
        .FRAME_CYCLES(FRAME_LEN)) host_cpu_irq_status_mask_i (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .link(lk.dev),
        .wakeup_sent_i(ev[5]), .clk_stable_i(ev[4]),
        .downstream_suspended_i(down_susp), .opr_event_i(ev[3]),
        .ext_eot_i(ev[2]), .byte_strobe_i(ev[0]), .async_ready_i(ev[1]),
        .host_irq_status_i(hirq), .buffer_fill_status_i(bfill),
        .sof_mark_o(sof), .suspended_o(susp), .host_control_o(hctl));
    cpu_irq_host_ctrl cpu_irq_host_ctrl_i (.clk_i(clk_i), .rst_i(rst_i),
        .ce_i(1'b1), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hF), .dat_i(dat), .dat_o(wb_q), .ack_o(wb_ack),
        .irq_o(irq), .link(lk.host));
    cpu_irq_link_monitor cpu_irq_link_monitor_i (.clk_i(clk_i),
        .rst_i(rst_i), .req(lk.req), .code(lk.code), .wdata(lk.wdata),
        .ack(lk.ack), .rdata(lk.rdata), .irq_out_pin(lk.irq_out_pin));
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got,
                exp);
        end
    endtask
    // Classic cycle: hold everything until ack is sampled
    task automatic wb(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        do @(posedge clk_i); while (wb_ack !== 1'b1);
        q = wb_q;
        cyc <= 1'b0;
        stb <= 1'b0;
    endtask
    // Device access through the controller; poll busy until done
    task automatic dev(input logic [7:0] c, input logic [15:0] d);
        logic [31:0] q;
        wb(1'b1, WB_CMD, {8'h00, c, d}, q);
        do wb(1'b0, WB_RESULT, 32'h0, q); while (q[BUSY_BIT] === 1'b1);
        rd = q[15:0];
    endtask
    task automatic pulse(input logic [5:0] e);
        @(posedge clk_i);
        ev <= e;
        @(posedge clk_i);
        ev <= 6'h00;
    endtask
    task automatic count_sof;
        n = 0;
        repeat (2 * FRAME_LEN) begin
            @(posedge clk_i);
            n += int'(sof === 1'b1);
        end
    endtask
    task automatic pin(input logic v);
        chk({15'h0, lk.irq_out_pin}, {15'h0, v});
    endtask
    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // Watchdog well beyond the several hundred cycles the tests need
    initial begin
        repeat (30000) @(posedge clk_i);
        mismatches++;
        end_sim();
    end
    initial begin
        // Reset asserted and the bus idle from time zero
        rst_i = 1'b1;
        {cyc, stb, we, down_susp} = 4'h0;
        adr = 8'h00;
        dat = 32'h0000_0000;
        ev = 6'h00;
        hirq = 16'hA55A;
        bfill = 16'h0C3C;
        mismatches = 0;
        checks_done = 0;
        repeat (4) @(posedge clk_i);
        rst_i <= 1'b0;
        dev(CODE_MASK_RD, 16'h0000);
        chk(rd, 16'h0000);
        pin(1'b0);
        dev(CODE_HOST_IRQ_RD, 16'h0000);
        chk(rd, 16'hA55A);
        dev(CODE_BUF_FILL_RD, 16'h0000);
        chk(rd, 16'h0C3C);
        $display("reset test done");
        foreach (rows[i]) begin
            dev(CODE_STATUS_WR, 16'hFFFF);
            pulse(rows[i].ev);
            repeat (READY_CYC + 5) @(posedge clk_i);
            dev(CODE_STATUS_RD, 16'h0000);
            chk(rd & 16'hFFFE, rows[i].exp);
        end
        $display("event table done");
        // Stable clock ends the wait well before its limit
        dev(CODE_STATUS_WR, 16'hFFFF);
        pulse(6'h20);
        pulse(6'h10);
        dev(CODE_STATUS_RD, 16'h0000);
        chk(rd & 16'h0040, 16'h0040);
        // Internal end on the third byte, not the second
        dev(CODE_BYTE_COUNT_WR, 16'h0003);
        dev(CODE_STATUS_WR, 16'hFFFF);
        pulse(6'h01);
        pulse(6'h01);
        dev(CODE_STATUS_RD, 16'h0000);
        chk(rd & 16'h0004, 16'h0000);
        pulse(6'h01);
        dev(CODE_STATUS_RD, 16'h0000);
        chk(rd & 16'h0004, 16'h0004);
        // Reads keep flags; write-one clears only its own bit
        pulse(6'h0A);
        dev(CODE_STATUS_RD, 16'h0000);
        dev(CODE_STATUS_RD, 16'h0000);
        chk(rd & 16'h00FE, 16'h0016);
        dev(CODE_STATUS_WR, 16'h0010);
        dev(CODE_STATUS_RD, 16'h0000);
        chk(rd & 16'h00FE, 16'h0006);
        dev(CODE_STATUS_WR, 16'h00FF);
        dev(CODE_STATUS_RD, 16'h0000);
        chk(rd & 16'h00FE, 16'h0000);
        count_sof();
        chk(n[15:0], 16'h0002);
        dev(CODE_STATUS_RD, 16'h0000);
        chk(rd & 16'h0001, 16'h0001);
        $display("flag tests done");
        dev(CODE_MASK_WR, 16'hFFFF);
        dev(CODE_MASK_RD, 16'h0000);
        chk(rd, 16'h0077);
        pulse(6'h08);
        dev(CODE_MASK_WR, 16'h0010);
        pin(1'b0);
        dev(CODE_HW_CONFIG_WR, 16'h0001);
        pin(1'b1);
        dev(CODE_MASK_WR, 16'h0004);
        pin(1'b0);
        dev(CODE_MASK_WR, 16'h0010);
        pin(1'b1);
        dev(CODE_STATUS_WR, 16'h0010);
        pin(1'b0);
        dev(CODE_HW_CONFIG_WR, 16'h0000);
        $display("pin tests done");
        // Controller interrupt: masked, then raised, cleared by read
        wb(1'b0, WB_IRQ_STATUS, 32'h0, wq);
        dev(CODE_MASK_RD, 16'h0000);
        chk({15'h0, irq}, 16'h0000);
        wb(1'b1, WB_IRQ_MASK, 32'h1, wq);
        chk({15'h0, irq}, 16'h0001);
        wb(1'b0, WB_IRQ_STATUS, 32'h0, wq);
        chk(wq[15:0] & 16'h0001, 16'h0001);
        chk({15'h0, irq}, 16'h0000);
        wb(1'b0, 8'h30, 32'h0, wq);
        chk(wq[15:0], 16'h0000);
        // Auto service: pin starts it, cause is read, seen flags cleared
        wb(1'b1, WB_IRQ_MASK, 32'h4, wq);
        wb(1'b1, WB_SERVICE, 32'h1, wq);
        dev(CODE_HW_CONFIG_WR, 16'h0001);
        pulse(6'h08);
        repeat (20) @(posedge clk_i);
        chk({15'h0, irq}, 16'h0001);
        wb(1'b0, WB_SNAPSHOT, 32'h0, wq);
        chk(wq[15:0] & 16'h00FE, 16'h0010);
        pin(1'b0);
        wb(1'b0, WB_SERVICE, 32'h0, wq);
        chk(wq[15:0], 16'h0001);
        wb(1'b1, WB_SERVICE, 32'h0, wq);
        dev(CODE_STATUS_RD, 16'h0000);
        chk(rd & 16'h00FE, 16'h0000);
        dev(CODE_HW_CONFIG_WR, 16'h0000);
        $display("controller tests done");
        // Suspend: flag set and frame marks stop
        dev(CODE_STATUS_WR, 16'hFFFF);
        down_susp <= 1'b1;
        dev(CODE_HOST_CONTROL_WR, 16'h0001);
        chk(hctl, 16'h0001);
        repeat (5) @(posedge clk_i);
        chk({15'h0, susp}, 16'h0001);
        count_sof();
        chk(n[15:0], 16'h0000);
        dev(CODE_STATUS_RD, 16'h0000);
        chk(rd & 16'h00FE, 16'h0020);
        // Second reset in mid-run clears the mask again
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        dev(CODE_MASK_RD, 16'h0000);
        chk(rd, 16'h0000);
        $display("suspend and reset tests done");
        end_sim();
    end
endmodule // host_cpu_irq_status_mask_tb_top
`default_nettype wire
